// file: include/pmbd_consts.svh
// constants for the peripheral map and bank decoder
// assumes a single 40 MHz clock domain and a 32-bit signed address space
//
// Functional notes
// - peripheral window spans 0x0000_0000 up to printed bound 0x03FF_FFFF.
// - peripheral registers reachable only by device-access load/store.
// - device access in window or to a listed 4K block goes to peripherals, elsewhere to memory.
// - ordinary load/store inside peripheral window goes to external memory.
// - each peripheral owns one 4K block, selected by address block.
// - memory interface config at 0x2000, diagnostic block at 0x3000.
// - peripheral bases 0x2000_0000 through signal processing at 0x2000_C000.
// - 64 Kbyte internal SRAM decoded upward from 0x8000_0000.
// - lowest bank at or above 0x8100_0000 goes to external RAM.
// - external memory interface offers a 16-bit data path, four banks.
// - each bank is one quarter of signed space, bank 0 lowest.
// - each bank has 64 config bits, accessed as four 16-bit words.
// - after reset every bank config defaults to slowest settings.
// - four per-bank locks block writes to that bank's config data.
// - global status register shows locked and configured per bank.
// - config space: sixteen 16-bit data words, four locks, one status.
// - 0x8000_0040 to 0x8000_0140 reserved for trap structures.
// - signal processing DMA channel state word at 0x8000_0014.
// - address bits 31 and 30 form the bank select.
// - 128K ROM occupies top of bank 3 from 0x7FFE_0000.
`ifndef PMBD_CONSTS_SVH
`define PMBD_CONSTS_SVH

// ===========================================================
// address map
`define PMBD_PERIPH_LO       32'h0000_0000
`define PMBD_PERIPH_HI       32'h03FF_FFFF
`define PMBD_BLOCK_LSB       12
`define PMBD_EMI_BASE        32'h0000_2000
`define PMBD_DIAG_BASE       32'h0000_3000
`define PMBD_INTC_BASE       32'h2000_0000
`define PMBD_ILC_BASE        32'h2000_1000
`define PMBD_TIMER_BASE      32'h2000_2000
`define PMBD_SER0_BASE       32'h2000_4000
`define PMBD_SER1_BASE       32'h2000_6000
`define PMBD_PIOA_BASE       32'h2000_8000
`define PMBD_PIOB_BASE       32'h2000_A000
`define PMBD_DSP_BASE        32'h2000_C000
`define PMBD_SRAM_BASE       32'h8000_0000
`define PMBD_SRAM_TOP        32'h8000_FFFF
`define PMBD_EXTRAM_BASE     32'h8100_0000
`define PMBD_BANK1_BASE      32'hC000_0000
`define PMBD_ROM_BASE        32'h7FFE_0000
`define PMBD_ROM_TOP         32'h7FFF_FFFF
`define PMBD_TRAP_BASE       32'h8000_0040
`define PMBD_USER_START      32'h8000_0140
`define PMBD_DMA_STATE       32'h8000_0014

// ===========================================================
// configuration space offsets inside the memory interface block
`define PMBD_CFG_OFF_MSB     11
`define PMBD_CFG_DATA_LIM    12'h0_40
`define PMBD_CFG_LOCK_BASE   12'h0_40
`define PMBD_CFG_LOCK_SLOT   8'h04
`define PMBD_CFG_STAT_OFF    12'h0_50
`define PMBD_CFG_DEFAULT     16'h1_FF1
`define PMBD_CFG_WORDS       4
`define PMBD_BANKS           4

`endif

// file: include/pmbd_pkg.sv
// types for the peripheral map and bank decoder
// assumes pmbd_consts.svh is on the include path
package pmbd_pkg;

  // ===========================================================
  // route targets
  typedef enum logic [2:0] {
    PMBD_TGT_NONE   = 3'b000,
    PMBD_TGT_PERIPH = 3'b001,
    PMBD_TGT_SRAM   = 3'b010,
    PMBD_TGT_ROM    = 3'b011,
    PMBD_TGT_EXTMEM = 3'b100,
    PMBD_TGT_RSVD   = 3'b101
  } pmbd_target_e;

  typedef enum logic [1:0] {
    PMBD_ST_IDLE = 2'b00,
    PMBD_ST_RESP = 2'b01
  } pmbd_state_e;

endpackage

// file: design/pmbd_decode.sv
// peripheral map and bank decoder with memory interface config store
// assumes the core holds a request until one cycle after it is taken
`timescale 1ns/1ps
`include "pmbd_consts.svh"

module pmbd_decode (
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // core request
  input  wire logic        REQ_VALID_I,
  input  wire logic        REQ_DEVICE_I,
  input  wire logic        REQ_WRITE_I,
  input  wire logic [31:0] REQ_ADDR_I,
  input  wire logic [15:0] REQ_WDATA_I,
  // routing result
  output logic             ROUTE_VALID_O,
  output logic [2:0]       ROUTE_TARGET_O,
  output logic [3:0]       ROUTE_BANK_SEL_O,
  output logic [3:0]       ROUTE_PERIPH_IDX_O,
  output logic             ROUTE_PERIPH_HIT_O,
  output logic             ROUTE_CFG_HIT_O,
  output logic             ROUTE_TRAP_AREA_O,
  output logic             ROUTE_DMA_WORD_O,
  output logic [15:0]      ROUTE_RDATA_O,
  // config store view
  output logic [63:0]      CFG_BANK0_O,
  output logic [63:0]      CFG_BANK1_O,
  output logic [63:0]      CFG_BANK2_O,
  output logic [63:0]      CFG_BANK3_O,
  output logic [3:0]       CFG_LOCKED_O,
  output logic [3:0]       CFG_DONE_O
);

  // ===========================================================
  // reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ===========================================================
  // decode functions
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // signed compare: flip the sign bit so unsigned order matches
  function automatic logic [31:0] ord(input logic [31:0] a);
    ord = {~a[31], a[30:0]};
  endfunction

  // slot decode, shared by the write strobes and the read mux
  function automatic logic is_data_slot(input logic [11:0] off);
    is_data_slot = (off < `PMBD_CFG_DATA_LIM);
  endfunction

  function automatic logic is_lock_slot(input logic [11:0] off);
    is_lock_slot = (off[11:4] == `PMBD_CFG_LOCK_SLOT);
  endfunction

  function automatic logic [3:0] periph_index(input logic [31:0] a);
    logic [31:0] blk;
    blk = a & ~((32'h0000_0001 << `PMBD_BLOCK_LSB) - 32'h0000_0001);
    case (blk)
      `PMBD_EMI_BASE:                       periph_index = 4'h1;
      `PMBD_DIAG_BASE:                      periph_index = 4'h2;
      `PMBD_INTC_BASE:                      periph_index = 4'h3;
      `PMBD_ILC_BASE:                       periph_index = 4'h4;
      `PMBD_TIMER_BASE:                     periph_index = 4'h5;
      `PMBD_SER0_BASE:                      periph_index = 4'h6;
      `PMBD_SER1_BASE:                      periph_index = 4'h7;
      `PMBD_PIOA_BASE:                      periph_index = 4'h8;
      `PMBD_PIOB_BASE:                      periph_index = 4'h9;
      `PMBD_DSP_BASE:                       periph_index = 4'hA;
      default:                              periph_index = 4'h0;
    endcase
  endfunction

  // ===========================================================
  // combinational routing
  logic                   hit_periph;
  logic [3:0]             pidx;
  logic [1:0]             bank;
  pmbd_pkg::pmbd_target_e tgt;
  logic                   cfg_hit;
  logic [11:0]            cfg_off;
  logic                   in_window;
  logic                   known_blk;
  logic                   in_sram;
  logic                   in_rom;
  logic                   in_gap;
  logic                   in_trap;
  logic                   is_dma;

  // listed 4K blocks above the printed window bound still decode
  assign in_window = in_range(REQ_ADDR_I, `PMBD_PERIPH_LO,
                              `PMBD_PERIPH_HI);
  assign known_blk = (pidx != 4'h0);
  assign in_sram   = in_range(ord(REQ_ADDR_I), ord(`PMBD_SRAM_BASE),
                              ord(`PMBD_SRAM_TOP));
  assign in_rom    = in_range(ord(REQ_ADDR_I), ord(`PMBD_ROM_BASE),
                              ord(`PMBD_ROM_TOP));
  assign in_gap    = (bank == 2'b00)
                     && (ord(REQ_ADDR_I) < ord(`PMBD_EXTRAM_BASE));
  assign in_trap   = (REQ_ADDR_I >= `PMBD_TRAP_BASE)
                     && (REQ_ADDR_I < `PMBD_USER_START);
  assign is_dma    = (REQ_ADDR_I[31:2]
                      == 30'(`PMBD_DMA_STATE >> 2));

  always_comb begin
    bank       = REQ_ADDR_I[31:30] ^ 2'b10;
    pidx       = periph_index(REQ_ADDR_I);
    hit_periph = REQ_DEVICE_I
                 && (in_window || known_blk);
    cfg_off    = REQ_ADDR_I[`PMBD_CFG_OFF_MSB:0];
    cfg_hit    = hit_periph && (pidx == 4'h1);
    if (hit_periph) begin
      tgt = known_blk ? pmbd_pkg::PMBD_TGT_PERIPH
                      : pmbd_pkg::PMBD_TGT_RSVD;
    end else if (in_sram) begin
      tgt = pmbd_pkg::PMBD_TGT_SRAM;
    end else if (in_rom) begin
      tgt = pmbd_pkg::PMBD_TGT_ROM;
    end else if (in_gap) begin
      tgt = pmbd_pkg::PMBD_TGT_NONE;                     // gap above sram
    end else begin
      tgt = pmbd_pkg::PMBD_TGT_EXTMEM;
    end
  end

  // ===========================================================
  // configuration store: 4 banks x 4 words of 16 bits
  logic [15:0] cfg_q [`PMBD_BANKS][`PMBD_CFG_WORDS];
  logic [3:0]  lock_q;
  logic [3:0]  written_q [`PMBD_BANKS];
  logic [3:0]  done_q;
  logic [1:0]  cb;
  logic [1:0]  cw;
  logic        data_slot;
  logic        lock_slot;
  logic        stat_slot;
  logic        cfg_wr;
  logic        data_wr;
  logic        lock_wr;

  // data words sit on word boundaries: bank in [5:4], word in [3:2]
  assign cb        = cfg_off[5:4];
  assign cw        = cfg_off[3:2];
  assign data_slot = is_data_slot(cfg_off);
  assign lock_slot = is_lock_slot(cfg_off);
  assign stat_slot = (cfg_off == `PMBD_CFG_STAT_OFF);
  // only a taken device write may touch the store
  assign cfg_wr    = REQ_VALID_I && REQ_WRITE_I && cfg_hit;
  assign data_wr   = cfg_wr && data_slot;
  assign lock_wr   = cfg_wr && lock_slot;

  genvar gb;
  genvar gw;
  generate
    for (gb = 0; gb < `PMBD_BANKS; gb++) begin : g_bank
      for (gw = 0; gw < `PMBD_CFG_WORDS; gw++) begin : g_word
        always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
          if (!rst_n_q) begin
            cfg_q[gb][gw] <= `PMBD_CFG_DEFAULT;
          end else if (data_wr && cb == gb && cw == gw
                       && !lock_q[gb]) begin
            cfg_q[gb][gw] <= REQ_WDATA_I;
          end
        end
      end

      // configured once all four words have landed
      always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
          written_q[gb] <= 4'h0;
        end else if (data_wr && cb == gb && !lock_q[gb]) begin
          written_q[gb] <= written_q[gb] | (4'h1 << cw);
        end
      end

      always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
          lock_q[gb] <= 1'b0;
        end else if (lock_wr && cfg_off[3:2] == gb) begin
          lock_q[gb] <= REQ_WDATA_I[0];
        end
      end

      assign done_q[gb] = &written_q[gb];
    end
  endgenerate

  // ===========================================================
  // read data for config space
  logic [15:0] rdata;

  always_comb begin
    rdata = 16'h0000;
    if (cfg_hit && !REQ_WRITE_I) begin
      if (data_slot) begin
        rdata = cfg_q[cb][cw];
      end else if (lock_slot) begin
        rdata = {15'h0000, lock_q[cfg_off[3:2]]};
      end else if (stat_slot) begin
        rdata = {8'h00, done_q, lock_q};
      end
    end
  end

  // ===========================================================
  // registered outputs, one block per concern
  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ROUTE_VALID_O  <= 1'b0;
      ROUTE_TARGET_O <= 3'h0;
    end else begin
      ROUTE_VALID_O  <= REQ_VALID_I;
      ROUTE_TARGET_O <= tgt;
    end
  end

  // strobe only for external memory; 16-bit path per bank
  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ROUTE_BANK_SEL_O <= 4'h0;
    end else if (REQ_VALID_I && tgt == pmbd_pkg::PMBD_TGT_EXTMEM) begin
      ROUTE_BANK_SEL_O <= 4'h1 << bank;
    end else begin
      ROUTE_BANK_SEL_O <= 4'h0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ROUTE_PERIPH_IDX_O <= 4'h0;
      ROUTE_PERIPH_HIT_O <= 1'b0;
      ROUTE_CFG_HIT_O    <= 1'b0;
    end else begin
      ROUTE_PERIPH_IDX_O <= hit_periph ? pidx : 4'h0;
      ROUTE_PERIPH_HIT_O <= REQ_VALID_I && hit_periph;
      ROUTE_CFG_HIT_O    <= REQ_VALID_I && cfg_hit;
    end
  end

  // trap and DMA flags are raised for a valid access in their own area that is not a peripheral hit
  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ROUTE_TRAP_AREA_O <= 1'b0;
      ROUTE_DMA_WORD_O  <= 1'b0;
    end else begin
      ROUTE_TRAP_AREA_O <= REQ_VALID_I && !hit_periph && in_trap;
      ROUTE_DMA_WORD_O  <= REQ_VALID_I && !hit_periph && is_dma;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ROUTE_RDATA_O <= 16'h0000;
    end else begin
      ROUTE_RDATA_O <= rdata;
    end
  end

  // ===========================================================
  // bank view, words {3,2,1,0}; lags the store by a cycle
  function automatic logic [63:0] pack_bank(input logic [1:0] b);
    pack_bank = {cfg_q[b][3], cfg_q[b][2], cfg_q[b][1], cfg_q[b][0]};
  endfunction

  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      CFG_BANK0_O <= {4{`PMBD_CFG_DEFAULT}};
    end else begin
      CFG_BANK0_O <= pack_bank(2'h0);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      CFG_BANK1_O <= {4{`PMBD_CFG_DEFAULT}};
    end else begin
      CFG_BANK1_O <= pack_bank(2'h1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      CFG_BANK2_O <= {4{`PMBD_CFG_DEFAULT}};
    end else begin
      CFG_BANK2_O <= pack_bank(2'h2);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      CFG_BANK3_O <= {4{`PMBD_CFG_DEFAULT}};
    end else begin
      CFG_BANK3_O <= pack_bank(2'h3);
    end
  end

  // software must finish a bank before using it
  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      CFG_LOCKED_O <= 4'h0;
      CFG_DONE_O   <= 4'h0;
    end else begin
      CFG_LOCKED_O <= lock_q;
      CFG_DONE_O   <= done_q;
    end
  end

endmodule

// file: verif/pmbd_decode_properties.sv
// concurrent checks on the ports of the peripheral map and bank decoder
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module pmbd_decode_properties (
  // clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  // core request
  input wire logic        REQ_VALID_I,
  input wire logic        REQ_DEVICE_I,
  input wire logic [31:0] REQ_ADDR_I,
  // routing result
  input wire logic        ROUTE_VALID_O,
  input wire logic [2:0]  ROUTE_TARGET_O,
  input wire logic [3:0]  ROUTE_BANK_SEL_O,
  input wire logic [3:0]  ROUTE_PERIPH_IDX_O,
  input wire logic        ROUTE_PERIPH_HIT_O,
  input wire logic        ROUTE_CFG_HIT_O,
  input wire logic        ROUTE_TRAP_AREA_O,
  input wire logic        ROUTE_DMA_WORD_O,
  // config store view
  input wire logic [3:0]  CFG_DONE_O
);
  // ==========================================================
  // helpers
  logic       win_req;
  logic       dev_req;
  logic       trap_req;
  logic [1:0] bank_idx;
  assign win_req  = REQ_VALID_I && (REQ_ADDR_I <= 32'h03FF_FFFF);
  assign dev_req  = REQ_VALID_I && REQ_DEVICE_I;
  assign trap_req = REQ_VALID_I && (REQ_ADDR_I >= 32'h8000_0040)
                    && (REQ_ADDR_I < 32'h8000_0140);
  // bank 0 sits at the bottom of the signed space
  assign bank_idx = REQ_ADDR_I[31:30] ^ 2'b10;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // ==========================================================
  // routing
  a_window_hit: assert property (win_req && REQ_DEVICE_I |=>
    ROUTE_PERIPH_HIT_O && ROUTE_VALID_O) else $error("window miss");
  a_hit_device: assert property (ROUTE_PERIPH_HIT_O |->
    $past(dev_req)) else $error("hit without device access");
  a_plain_ext: assert property (win_req && !REQ_DEVICE_I |=>
    ROUTE_TARGET_O == pmbd_pkg::PMBD_TGT_EXTMEM && !ROUTE_PERIPH_HIT_O)
    else $error("plain access not sent to memory");
  a_cfg_block: assert property (dev_req &&
    REQ_ADDR_I[31:12] == 20'h0_0002 |=> ROUTE_CFG_HIT_O
    && ROUTE_PERIPH_IDX_O == 4'h1) else $error("config block miss");
  a_diag_block: assert property (dev_req &&
    REQ_ADDR_I[31:12] == 20'h0_0003 |=> ROUTE_PERIPH_IDX_O == 4'h2)
    else $error("diagnostic block miss");
  a_dsp_block: assert property (dev_req &&
    REQ_ADDR_I[31:12] == 20'h2_000C |=> ROUTE_PERIPH_IDX_O == 4'hA)
    else $error("signal block miss");
  a_sram_range: assert property (REQ_VALID_I &&
    REQ_ADDR_I[31:16] == 16'h8000 |=>
    ROUTE_TARGET_O == pmbd_pkg::PMBD_TGT_SRAM) else $error("sram miss");
  a_ext_ram: assert property (REQ_VALID_I &&
    REQ_ADDR_I[31:30] == 2'b10 && REQ_ADDR_I[29:24] != 6'h00 |=>
    ROUTE_TARGET_O == pmbd_pkg::PMBD_TGT_EXTMEM
    && ROUTE_BANK_SEL_O == 4'h1) else $error("external ram miss");
  a_bank_select: assert property (
    ROUTE_VALID_O && ROUTE_TARGET_O == pmbd_pkg::PMBD_TGT_EXTMEM |->
    ROUTE_BANK_SEL_O == (4'h1 << $past(bank_idx)))
    else $error("wrong bank strobe");
  a_rom_top: assert property (REQ_VALID_I &&
    REQ_ADDR_I[31:17] == 15'h3FFF |=>
    ROUTE_TARGET_O == pmbd_pkg::PMBD_TGT_ROM) else $error("rom miss");
  a_trap_area: assert property (ROUTE_TRAP_AREA_O == $past(trap_req))
    else $error("trap area flag wrong");
  a_dma_word: assert property (REQ_VALID_I &&
    REQ_ADDR_I == 32'h8000_0014 |=> ROUTE_DMA_WORD_O)
    else $error("dma word miss");
  // the flag only clears through reset
  a_done_sticky: assert property (
    (CFG_DONE_O & $past(CFG_DONE_O)) == $past(CFG_DONE_O))
    else $error("configured flag dropped");
endmodule

bind pmbd_decode pmbd_decode_properties u_pmbd_decode_properties (.*);

// file: verif/pmbd_core_model.sv
// behavioural core issuing loads, stores and device accesses
// assumes the caller invokes issue from one process at a time
`timescale 1ns/1ps
module pmbd_core_model (
  // clock
  input  wire logic        clk_i,
  // request
  output logic             valid_o,
  output logic             device_o,
  output logic             write_o,
  output logic [31:0]      addr_o,
  output logic [15:0]      wdata_o
);
  initial begin
    valid_o  = 1'b0;
    device_o = 1'b0;
    write_o  = 1'b0;
    addr_o   = 32'h0000_0000;
    wdata_o  = 16'h0000;
  end
  // bank setup order is left to the caller
  task automatic issue(input logic d, input logic w,
                       input logic [31:0] a, input logic [15:0] wd);
    @(posedge clk_i);
    #2;
    valid_o  = 1'b1;
    device_o = d;
    write_o  = w;
    addr_o   = a;
    wdata_o  = wd;
    @(posedge clk_i);
    #2;
    // released lines show garbage, not the last value
    valid_o  = 1'b0;
    device_o = ~d;
    write_o  = ~w;
    addr_o   = ~a;
    wdata_o  = ~wd;
  endtask
endmodule

// file: verif/pmbd_decode_tb.sv
// self-checking bench for the peripheral map and bank decoder
// assumes the core model drives requests and the checker is bound in
`timescale 1ns/1ps
module pmbd_decode_tb;
  typedef struct packed {
    logic        d;
    logic [31:0] a;
    logic [2:0]  t;
    logic [3:0]  i;
    logic [3:0]  b;
  } pmbd_row_s;
  logic        clk_sys, rst_n, valid, device, write, r_valid, hit;
  logic        cfg_hit, trap, dma;
  logic [31:0] addr;
  logic [15:0] wdata, rdata;
  logic [2:0]  tgt;
  logic [3:0]  bank, idx, locked, done;
  logic [63:0] cfg0, cfg1, cfg2, cfg3;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // skip markers: target 7, index and bank F; target 1 means a hit
  pmbd_row_s   rows [20] = '{
    '{1'b1, 32'h0000_2000, 3'h1, 4'h1, 4'h0},
    '{1'b1, 32'h0000_3000, 3'h1, 4'h2, 4'h0},
    '{1'b1, 32'h2000_0000, 3'h1, 4'h3, 4'h0},
    '{1'b1, 32'h2000_1000, 3'h1, 4'h4, 4'h0},
    '{1'b1, 32'h2000_2000, 3'h1, 4'h5, 4'h0},
    '{1'b1, 32'h2000_4000, 3'h1, 4'h6, 4'h0},
    '{1'b1, 32'h2000_6000, 3'h1, 4'h7, 4'h0},
    '{1'b1, 32'h2000_8000, 3'h1, 4'h8, 4'h0},
    '{1'b1, 32'h2000_A000, 3'h1, 4'h9, 4'h0},
    '{1'b1, 32'h2000_C000, 3'h1, 4'hA, 4'h0},
    '{1'b0, 32'h0000_2000, 3'h4, 4'hF, 4'h4},
    '{1'b0, 32'h8000_0000, 3'h2, 4'hF, 4'h0},
    '{1'b1, 32'h8000_FFFF, 3'h2, 4'hF, 4'h0},
    '{1'b0, 32'h8100_0000, 3'h4, 4'hF, 4'h1},
    '{1'b0, 32'hC000_0000, 3'h4, 4'hF, 4'h2},
    '{1'b0, 32'h4000_0000, 3'h4, 4'hF, 4'h8},
    '{1'b0, 32'h7FFE_0000, 3'h3, 4'hF, 4'h0},
    '{1'b0, 32'h8001_0000, 3'h0, 4'hF, 4'h0},
    '{1'b0, 32'h8000_0014, 3'h2, 4'hF, 4'h0},
    '{1'b0, 32'h8000_0040, 3'h2, 4'hF, 4'h0}};

  pmbd_core_model u_pmbd_core_model (.clk_i(clk_sys), .valid_o(valid),
    .device_o(device), .write_o(write), .addr_o(addr), .wdata_o(wdata));
  pmbd_decode u_pmbd_decode (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n),
    .REQ_VALID_I(valid), .REQ_DEVICE_I(device), .REQ_WRITE_I(write),
    .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata), .ROUTE_VALID_O(r_valid),
    .ROUTE_TARGET_O(tgt), .ROUTE_BANK_SEL_O(bank), .ROUTE_PERIPH_IDX_O(idx),
    .ROUTE_PERIPH_HIT_O(hit), .ROUTE_CFG_HIT_O(cfg_hit),
    .ROUTE_TRAP_AREA_O(trap), .ROUTE_DMA_WORD_O(dma), .ROUTE_RDATA_O(rdata),
    .CFG_BANK0_O(cfg0), .CFG_BANK1_O(cfg1), .CFG_BANK2_O(cfg2),
    .CFG_BANK3_O(cfg3), .CFG_LOCKED_O(locked), .CFG_DONE_O(done));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [63:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic settle();
    @(posedge clk_sys);
    #2;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // whole run is under a hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    rst_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #2;
    chk("bank0 default", 64'h1FF1_1FF1_1FF1_1FF1, cfg0);
    chk("bank3 default", 64'h1FF1_1FF1_1FF1_1FF1, cfg3);
    rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 20; k++) begin
      u_pmbd_core_model.issue(rows[k].d, 1'b0, rows[k].a, 16'h0000);
      chk("valid", 1'b1, r_valid);
      if (rows[k].t != 3'h7) chk("target", rows[k].t, tgt);
      if (rows[k].i != 4'hF) chk("index", rows[k].i, idx);
      if (rows[k].b != 4'hF) chk("bank", rows[k].b, bank);
      chk("hit", rows[k].d && rows[k].t == 3'h1, hit);
    end
    $display("test map done");
    for (int w = 0; w < 3; w++)
      u_pmbd_core_model.issue(1'b1, 1'b1, 32'h0000_2000 + 32'(w * 4),
                              16'hA5A0 + 16'(w));
    settle();
    chk("done early", 4'h0, done);
    u_pmbd_core_model.issue(1'b1, 1'b1, 32'h0000_200C, 16'hA5A3);
    settle();
    chk("bank0", 64'hA5A3_A5A2_A5A1_A5A0, cfg0);
    chk("done", 4'h1, done);
    u_pmbd_core_model.issue(1'b0, 1'b1, 32'h0000_2008, 16'hFFFF);
    settle();
    chk("plain write", 64'hA5A3_A5A2_A5A1_A5A0, cfg0);
    u_pmbd_core_model.issue(1'b1, 1'b0, 32'h0000_2004, 16'h0000);
    chk("readback", 16'hA5A1, rdata);
    u_pmbd_core_model.issue(1'b1, 1'b1, 32'h0000_2044, 16'h0001);
    u_pmbd_core_model.issue(1'b1, 1'b1, 32'h0000_2010, 16'h1234);
    settle();
    chk("locked", 4'h2, locked);
    chk("bank1", 64'h1FF1_1FF1_1FF1_1FF1, cfg1);
    u_pmbd_core_model.issue(1'b1, 1'b0, 32'h0000_2050, 16'h0000);
    chk("status", 16'h0012, rdata);
    u_pmbd_core_model.issue(1'b1, 1'b0, 32'h0000_2060, 16'h0000);
    chk("unmapped", 16'h0000, rdata);
    u_pmbd_core_model.issue(1'b1, 1'b1, 32'h0000_2044, 16'h0000);
    settle();
    chk("unlocked", 4'h0, locked);
    $display("test config done");
    rst_n = 1'b0;
    settle();
    chk("reset done", 4'h0, done);
    chk("reset bank0", 64'h1FF1_1FF1_1FF1_1FF1, cfg0);
    rst_n = 1'b1;
    $display("test reset done");
    test_done();
  end
endmodule
